// file: pkg/dop_map.svh
`ifndef DOP_MAP_SVH
`define DOP_MAP_SVH

`define DOP_CODE_W 10
`define DOP_MSB 9
`define DOP_LATENCY 5
`define DOP_CODE_RST 10'h200
`define DOP_FIFO_W 20
`define DOP_FIFO_DEPTH 8

`endif

// file: pkg/dop_pkg.sv
`include "dop_map.svh"

package dop_pkg;

  typedef logic [`DOP_CODE_W-1:0] dop_code_t;

  typedef struct packed {
    dop_code_t a;
    dop_code_t b;
  } dop_pair_s;

  typedef struct packed {
    logic fmt_twos;
    logic sleep;
    logic shutdown;
    logic out_en_n;
  } dop_ctrl_s;

  typedef enum logic [2:0] {
    DOP_RUN = 3'b001,
    DOP_HALT = 3'b010,
    DOP_WAKE = 3'b100
  } dop_state_e;

endpackage

// file: hdl/dop_fifo.sv
`timescale 1ns/10ps
`default_nettype none

module dop_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic wr, rd;

  always_comb begin
    in_ready = (cnt_q != (AW+1)'(DEPTH));
    out_valid = (cnt_q != '0);
    out_data = mem[rp_q];
    wr = in_valid && in_ready;
    rd = out_valid && out_ready;
    wp_d = wr ? AW'(wp_q + 1'b1) : wp_q;
    rp_d = rd ? AW'(rp_q + 1'b1) : rp_q;
    cnt_d = cnt_q;
    if (wr && !rd) begin
      cnt_d = cnt_q + 1'b1;
    end else if (rd && !wr) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (wr) begin
      mem[wp_q] <= in_data;
    end
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end
endmodule

`default_nettype wire

// file: hdl/dop_port.sv
`timescale 1ns/10ps
`default_nettype none
`include "dop_map.svh"

// Contract
// R1 - sample both channels every rising clock edge
// R2 - code reaches outputs five cycles after capture
// R3 - words change on rising edge, captured next
// R4 - format low offset binary, high twos complement
// R5 - twos complement is offset code, msb inverted
// R6 - output enable high releases all twenty lines
// R7 - shutdown with outputs enabled holds last code
// R8 - sleep stops conversion on both channels
// R9 - separate A and B words, one clock
// R10 - output enable is active low
// R11 - shutdown high powers down, low runs
// R12 - bit 9 msb, bit 0 lsb
// R13 - pipeline frozen in sleep/shutdown, five-cycle wake
module dop_port (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // converter samples, offset binary, bit 9 msb
  input wire dop_pkg::dop_pair_s sample_in,
  // control pins
  input wire dop_pkg::dop_ctrl_s ctrl_in,
  // fifo back-pressure to the sample source
  output logic sample_ready,
  // output words, two signals per pin
  output dop_pkg::dop_code_t chan_a_code,
  output dop_pkg::dop_code_t chan_b_code,
  output logic [2*`DOP_CODE_W-1:0] code_oe_n,
  output logic code_valid
);
  import dop_pkg::*;

  dop_state_e st_q, st_d;
  dop_pair_s pipe_q [`DOP_LATENCY-1];
  dop_pair_s pipe_d [`DOP_LATENCY-1];
  logic [`DOP_LATENCY-2:0] pv_q, pv_d;
  logic [2:0] wake_q, wake_d;
  dop_code_t a_q, a_d, b_q, b_d;
  logic [2*`DOP_CODE_W-1:0] oe_q, oe_d;
  logic vld_q, vld_d, rdy_q, rdy_d;
  logic halt, adv, f_valid, f_ready;
  dop_pair_s f_data;

  // sample buffer; neither fills nor drains while halted, so no stale
  // samples pile up and the latency stays fixed after wake-up
  dop_fifo #(.WIDTH(`DOP_FIFO_W), .DEPTH(`DOP_FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(!halt), // R1 R8
    .in_ready(f_ready),
    .in_data(sample_in),
    .out_valid(f_valid),
    .out_ready(adv),
    .out_data(f_data)
  );

  always_comb begin
    halt = ctrl_in.sleep || ctrl_in.shutdown; // R8 R11
    adv = !halt && f_valid; // R1 R13
    st_d = st_q;
    wake_d = wake_q;
    unique case (st_q)
      DOP_RUN: begin
        if (halt) st_d = DOP_HALT;
      end
      DOP_HALT: begin
        if (!halt) begin
          st_d = DOP_WAKE;
          wake_d = '0;
        end
      end
      DOP_WAKE: begin
        if (halt) begin
          st_d = DOP_HALT;
        end else if (wake_q == 3'(`DOP_LATENCY - 1)) begin
          st_d = DOP_RUN; // R13
        end else begin
          wake_d = wake_q + 3'h1;
        end
      end
    endcase
    pipe_d = pipe_q;
    pv_d = pv_q;
    if (adv) begin
      // R2: four stages plus the output latch
      pipe_d[0] = f_data;
      pv_d[0] = 1'b1;
      for (int i = 1; i < `DOP_LATENCY - 1; i++) begin
        pipe_d[i] = pipe_q[i-1];
        pv_d[i] = pv_q[i-1];
      end
    end
    a_d = a_q;
    b_d = b_q;
    vld_d = vld_q;
    if (adv) begin
      // R4 R5 R9 R12
      a_d = pipe_q[`DOP_LATENCY-2].a ^ {ctrl_in.fmt_twos, 9'h000};
      b_d = pipe_q[`DOP_LATENCY-2].b ^ {ctrl_in.fmt_twos, 9'h000};
      vld_d = pv_q[`DOP_LATENCY-2] && (st_q == DOP_RUN); // R3 R13
    end else if (halt) begin
      vld_d = 1'b0; // R7: codes held, marked stale
    end
    oe_d = {2*`DOP_CODE_W{ctrl_in.out_en_n}}; // R6 R10
    rdy_d = f_ready && !halt; // R8
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= DOP_HALT;
      wake_q <= '0;
      pv_q <= '0;
      a_q <= `DOP_CODE_RST;
      b_q <= `DOP_CODE_RST;
      vld_q <= 1'b0;
      oe_q <= '1;
      rdy_q <= 1'b0;
      for (int i = 0; i < `DOP_LATENCY - 1; i++) begin
        pipe_q[i] <= '0;
      end
    end else begin
      st_q <= st_d;
      wake_q <= wake_d;
      pv_q <= pv_d;
      pipe_q <= pipe_d;
      a_q <= a_d;
      b_q <= b_d;
      vld_q <= vld_d;
      oe_q <= oe_d;
      rdy_q <= rdy_d;
    end
  end

  assign chan_a_code = a_q;
  assign chan_b_code = b_q;
  assign code_oe_n = oe_q;
  assign code_valid = vld_q;
  assign sample_ready = rdy_q;
endmodule

`default_nettype wire

// file: dv/dop_port_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module dop_port_assertions (
  // clock, reset
  input wire logic core_clk,
  input wire logic rst,
  // inputs
  input wire dop_pkg::dop_pair_s sample_in,
  input wire dop_pkg::dop_ctrl_s ctrl_in,
  // outputs
  input wire logic sample_ready,
  input wire dop_pkg::dop_code_t chan_a_code,
  input wire dop_pkg::dop_code_t chan_b_code,
  input wire logic [19:0] code_oe_n,
  input wire logic code_valid
);
  import dop_pkg::*;
  logic ok_q;
  wire halt = ctrl_in.sleep | ctrl_in.shutdown;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // fixed latency is only checked from each reset until the next halt
  always_ff @(posedge core_clk) ok_q <= rst | ok_q & !halt;
  a_lat_chan_a: assert property (ok_q && code_valid |-> chan_a_code ==
    ($past(sample_in.a, 6) ^ {$past(ctrl_in.fmt_twos), 9'h000}))
    else $error("chan a code");
  a_lat_chan_b: assert property (ok_q && code_valid |-> chan_b_code ==
    ($past(sample_in.b, 6) ^ {$past(ctrl_in.fmt_twos), 9'h000}))
    else $error("chan b code");
  a_oe_release: assert property (ctrl_in.out_en_n |=> &code_oe_n)
    else $error("not released");
  a_oe_drive: assert property (!ctrl_in.out_en_n |=> code_oe_n == 0)
    else $error("not driven");
  a_shutdown_hold: assert property (ctrl_in.shutdown && !ctrl_in.out_en_n
    |=> $stable(chan_a_code) && $stable(chan_b_code)) else $error("no hold");
  a_sleep_stop: assert property (ctrl_in.sleep
    |=> !code_valid && $stable(chan_b_code)) else $error("sleep runs");
  a_wake_blank: assert property (halt |=> !code_valid [*5])
    else $error("early valid");
  a_reset_state: assert property ($fell(rst) |-> chan_a_code == 10'h200
    && &code_oe_n && !code_valid) else $error("reset state");
endmodule
bind dop_port dop_port_assertions u_chk (
  .core_clk(core_clk),
  .rst(rst),
  .sample_in(sample_in),
  .ctrl_in(ctrl_in),
  .sample_ready(sample_ready),
  .chan_a_code(chan_a_code),
  .chan_b_code(chan_b_code),
  .code_oe_n(code_oe_n),
  .code_valid(code_valid)
);
`default_nettype wire

// file: dv/dop_capture.sv
`timescale 1ns/10ps
`default_nettype none
module dop_capture (
  // clock
  input wire logic core_clk,
  // device words
  input wire dop_pkg::dop_code_t chan_a_code,
  input wire dop_pkg::dop_code_t chan_b_code,
  input wire logic [19:0] code_oe_n,
  // captured word
  output logic [19:0] cap_q
);
  // a released line shows the inverse of its last level
  wire [19:0] pin = code_oe_n & ~cap_q |
    ~code_oe_n & {chan_a_code, chan_b_code};
  always_ff @(posedge core_clk) cap_q <= pin;
endmodule
`default_nettype wire

// file: dv/dual_adc_output_port_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module dual_adc_output_port_tb_top;
  import dop_pkg::*;
  logic core_clk = 0;
  logic rst = 1;
  dop_pair_s sample_in = '0;
  dop_ctrl_s ctrl_in = '0;
  logic sample_ready, code_valid;
  dop_code_t chan_a_code, chan_b_code;
  logic [19:0] code_oe_n, cap_q;
  int fail_count = 0;
  int cmp_count = 0;
  // sample, format, expected captured word
  logic [40:0] rows [4] = '{{20'h803ff, 1'b0, 20'h803ff},
    {20'h001ff, 1'b1, 20'h803ff}, {20'hffe01, 1'b1, 20'h7fc01},
    {20'h00400, 1'b0, 20'h00400}};
  dop_port i_dut (
    .core_clk(core_clk),
    .rst(rst),
    .sample_in(sample_in),
    .ctrl_in(ctrl_in),
    .sample_ready(sample_ready),
    .chan_a_code(chan_a_code),
    .chan_b_code(chan_b_code),
    .code_oe_n(code_oe_n),
    .code_valid(code_valid)
  );
  dop_capture i_cap (
    .core_clk(core_clk),
    .chan_a_code(chan_a_code),
    .chan_b_code(chan_b_code),
    .code_oe_n(code_oe_n),
    .cap_q(cap_q)
  );
  always #50 core_clk = ~core_clk;
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("mismatches %0d of %0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (300) @(posedge core_clk);
    fail_count++;
    results;
  end
  // outputs are compared at the falling edge, where they are settled
  initial begin
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    chk({chan_a_code, chan_b_code}, 20'h80200);
    chk(code_oe_n, 20'hfffff);
    @(posedge core_clk);
    rst <= 0;
    for (int i = 0; i < 4; i++) begin
      sample_in <= rows[i][40:21];
      ctrl_in.fmt_twos <= rows[i][20];
      repeat (12) @(posedge core_clk);
      @(negedge core_clk);
      chk(cap_q, rows[i][19:0]);
      @(posedge core_clk);
    end
    ctrl_in.shutdown <= 1;
    sample_in <= 20'h15555;
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    chk({chan_a_code, chan_b_code}, 20'h00400);
    chk({19'h0, sample_ready}, 20'h0);
    @(posedge core_clk);
    ctrl_in <= 4'h5;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk(code_oe_n, 20'hfffff);
    chk({19'h0, code_valid}, 20'h0);
    // wake-up: the first new sample must show exactly six edges later
    @(posedge core_clk);
    ctrl_in <= 4'h0;
    sample_in <= 20'h48cf0;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    chk({chan_a_code, chan_b_code}, 20'h48cf0);
    chk({19'h0, code_valid}, 20'h0);
    @(posedge core_clk);
    @(negedge core_clk);
    chk({19'h0, code_valid}, 20'h1);
    chk(code_oe_n, 20'h0);
    // reset again in mid-run
    @(posedge core_clk);
    rst <= 1;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk({chan_a_code, chan_b_code}, 20'h80200);
    chk(code_oe_n, 20'hfffff);
    chk({19'h0, code_valid}, 20'h0);
    @(posedge core_clk);
    rst <= 0;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    chk({19'h0, code_valid}, 20'h0);
    @(posedge core_clk);
    @(negedge core_clk);
    chk({19'h0, code_valid}, 20'h1);
    chk({chan_a_code, chan_b_code}, 20'h48cf0);
    results;
  end
endmodule
`default_nettype wire
